// *** logic/mss_start_sequencer.sv ***
// Motor start sequencer: chooses how the motor is started after power-up or wake
//
// Contract
// - Enter power-on state at first power-up and on each wake from standby/sleep.
// - Direction change pending at start: treat probed rotation as reverse.
// - After power-on, probe if spin_probe_enable, else go to shorting decision.
// - Probe derives speed, position, direction from converter phase samples.
// - Probed back-EMF below stationary limit: stationary brake decision, else direction.
// - Stationary brake enable set starts stationary brake, else start-up.
// - Stationary brake holds all three low sides on for its duration.
// - Forward rotation goes to catch decision; reverse goes to reverse decision.
// - Catch enabled compares back-EMF to minimum; disabled goes to coast decision.
// - Back-EMF above minimum loads speed, position and enters closed loop.
// - Reverse drive enabled checks reverse speed, else coast decision.
// - Reverse closed loop while speed at/above handoff, then reverse open loop.
// - Reverse order: resync, closed decel, open decel, zero, open accel, closed. No resync here: no drive load, decision goes straight to decel.
// - Reverse drive only with probe and reverse enables and opposite rotation.
// - Reverse drive shares handoff speed, acceleration and current cap values.
// - Coast enable set starts coast, else shorting decision.
// - Coast turns off all six transistors for coast duration.
// - Shorting enable set starts brake, else start-up state.
// - Brake ends after duration or when all currents below limit, per select.
// - Brake shorts through high or low sides per side select.
// - Closed loop state commutates with trapezoidal control.
`timescale 1ns/1ps
module mss_start_sequencer
  import mss_pkg::*;
#(
  parameter int unsigned STAT_BRAKE_CYCLES = mss_pkg::STAT_BRAKE_CYC,
  parameter int unsigned COAST_CYCLES      = mss_pkg::COAST_CYC,
  parameter int unsigned BRAKE_CYCLES      = mss_pkg::BRAKE_CYC
) (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic                     wake,
  input  wire logic                     dir_change_pending,
  input  wire mss_pkg::mss_cfg_t        cfg,
  input  wire logic [mss_pkg::BEMF_W-1:0] sample_bemf,
  input  wire logic [mss_pkg::SPEED_W-1:0] sample_speed,
  input  wire logic [mss_pkg::POS_W-1:0] sample_position,
  input  wire logic                     sample_reverse,
  input  wire logic                     sample_valid,
  input  wire logic [3*mss_pkg::CURR_W-1:0] phase_current,
  input  wire logic [mss_pkg::SPEED_W-1:0] drive_speed,
  input  wire logic                     zero_crossed,
  input  wire logic                     forward_ready,
  input  wire logic                     startup_done,
  output logic                          probe_start,
  output logic                          startup_req,
  output logic                          drive_load,
  output mss_pkg::mss_drive_t           drive_mode,
  output logic                          drive_reverse,
  output logic                          trapezoid_run,
  output mss_pkg::mss_probe_t           drive_init,
  output mss_pkg::mss_gate_t            gate,
  output logic                          gate_override
);
  import mss_pkg::*;

  typedef enum logic [3:0] {
    S_POWER_ON, S_PROBE, S_DIR, S_STAT_BRAKE_DEC, S_STAT_BRAKE,
    S_CATCH_DEC, S_REV_DEC, S_REV_CLOSED, S_REV_OPEN, S_FWD_OPEN,
    S_COAST_DEC, S_COAST, S_SHORT_DEC, S_BRAKE, S_STARTUP, S_CLOSED
  } mss_state_t;

  mss_state_t state;
  mss_state_t next_state;
  mss_probe_t probe;
  logic       dir_forced;
  logic       timer_load;
  logic [TIMER_W-1:0] timer_cycles;
  logic       timer_done;
  logic       currents_low;
  logic       startup_issued;

  mss_timer #(.W(TIMER_W)) u_timer (
    .core_clk (core_clk),
    .nrst     (nrst),
    .load     (timer_load),
    .cycles   (timer_cycles),
    .done     (timer_done)
  );

  mss_current_cmp #(.W(CURR_W)) u_cmp (
    .phase_current (phase_current),
    .limit         (cfg.brake_current_limit),
    .all_below     (currents_low)
  );

  // Next state decision
  always_comb begin
    next_state = state;
    unique case (state)
      S_POWER_ON: begin
        next_state = cfg.spin_probe_enable ? S_PROBE : S_SHORT_DEC;
      end
      S_PROBE: begin
        if (sample_valid) begin
          next_state = (sample_bemf < cfg.stationary_bemf_limit) ? S_STAT_BRAKE_DEC
                                                                 : S_DIR;
        end
      end
      S_DIR: begin
        next_state = probe.reverse ? S_REV_DEC : S_CATCH_DEC;
      end
      S_STAT_BRAKE_DEC: begin
        next_state = cfg.stationary_brake_enable ? S_STAT_BRAKE : S_STARTUP;
      end
      S_STAT_BRAKE: if (timer_done) next_state = S_STARTUP;
      S_CATCH_DEC: begin
        if (!cfg.catch_spin_enable) begin
          next_state = S_COAST_DEC;
        end else if (probe.bemf > cfg.catch_spin_min_bemf) begin
          next_state = S_CLOSED;
        end else begin
          next_state = S_STAT_BRAKE_DEC;
        end
      end
      S_REV_DEC: begin
        // Reached only through a probe, so both enables gate reverse drive
        if (cfg.reverse_drive_enable) begin
          next_state = (probe.speed >= cfg.loop_handoff_speed) ? S_REV_CLOSED
                                                               : S_REV_OPEN;
        end else begin
          next_state = S_COAST_DEC;
        end
      end
      S_REV_CLOSED: begin
        if (drive_speed < cfg.loop_handoff_speed) next_state = S_REV_OPEN;
      end
      S_REV_OPEN: if (zero_crossed) next_state = S_FWD_OPEN;
      S_FWD_OPEN: if (forward_ready) next_state = S_CLOSED;
      S_COAST_DEC: begin
        next_state = cfg.coast_enable ? S_COAST : S_SHORT_DEC;
      end
      S_COAST: if (timer_done) next_state = S_SHORT_DEC;
      S_SHORT_DEC: begin
        next_state = cfg.shorting_stage_enable ? S_BRAKE : S_STARTUP;
      end
      S_BRAKE: begin
        if (cfg.brake_end_select ? currents_low : timer_done) next_state = S_STARTUP;
      end
      S_STARTUP: begin
        if (startup_issued && startup_done) next_state = S_CLOSED;
      end
      S_CLOSED: next_state = S_CLOSED;
    endcase
  end

  // State register; wake restarts the sequence
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_POWER_ON;
    end else if (wake) begin
      state <= S_POWER_ON;
    end else begin
      state <= next_state;
    end
  end

  // Direction change latched at the start of the sequence
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dir_forced <= 1'b0;
    end else if (wake || state == S_POWER_ON) begin
      dir_forced <= dir_change_pending;
    end
  end

  // Captured probe result
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      probe <= '0;
    end else if (!wake && state == S_PROBE && sample_valid) begin
      probe.bemf     <= sample_bemf;
      probe.speed    <= sample_speed;
      probe.position <= sample_position;
      probe.reverse  <= sample_reverse || dir_forced;
    end
  end

  // Timer loads on entry into a timed routine
  always_comb begin
    timer_load   = 1'b0;
    timer_cycles = '0;
    if (!wake && next_state != state) begin
      unique case (next_state)
        S_STAT_BRAKE: begin
          timer_load   = 1'b1;
          timer_cycles = TIMER_W'(STAT_BRAKE_CYCLES);
        end
        S_COAST: begin
          timer_load   = 1'b1;
          timer_cycles = TIMER_W'(COAST_CYCLES);
        end
        S_BRAKE: begin
          timer_load   = 1'b1;
          timer_cycles = TIMER_W'(BRAKE_CYCLES);
        end
        default: begin
          timer_load = 1'b0;
        end
      endcase
    end
  end

  // Single start request per entry into start-up
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      startup_issued <= 1'b0;
    end else if (state != S_STARTUP || wake) begin
      startup_issued <= 1'b0;
    end else begin
      startup_issued <= 1'b1;
    end
  end

  assign startup_req = (state == S_STARTUP) && !startup_issued && !wake;
  assign probe_start = (state == S_POWER_ON) && cfg.spin_probe_enable && !wake;

  // Drive loader pulse on entry into catch closed loop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drive_load <= 1'b0;
      drive_init <= '0;
    end else begin
      drive_load <= !wake && state == S_CATCH_DEC && next_state == S_CLOSED;
      if (!wake && state == S_CATCH_DEC && next_state == S_CLOSED) drive_init <= probe;
    end
  end

  // Power stage overrides and drive mode
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gate          <= GATE_OFF;
      gate_override <= 1'b1;
      drive_mode    <= MSS_DRV_IDLE;
      drive_reverse <= 1'b0;
      trapezoid_run <= 1'b0;
    end else begin
      gate          <= GATE_OFF;
      gate_override <= 1'b1;
      drive_mode    <= MSS_DRV_IDLE;
      drive_reverse <= 1'b0;
      trapezoid_run <= 1'b0;
      unique case (next_state)
        S_STAT_BRAKE: gate <= GATE_LOW;
        S_BRAKE:      gate <= cfg.brake_side_select ? GATE_HIGH : GATE_LOW;
        S_REV_CLOSED: begin
          gate_override <= 1'b0;
          drive_mode    <= MSS_DRV_REV_CLOSED;
          drive_reverse <= 1'b1;
        end
        S_REV_OPEN: begin
          gate_override <= 1'b0;
          drive_mode    <= MSS_DRV_REV_OPEN;
          drive_reverse <= 1'b1;
        end
        S_FWD_OPEN: begin
          gate_override <= 1'b0;
          drive_mode    <= MSS_DRV_REV_OPEN;
        end
        S_STARTUP:    gate_override <= 1'b0;
        S_CLOSED: begin
          gate_override <= 1'b0;
          drive_mode    <= MSS_DRV_CLOSED;
          trapezoid_run <= 1'b1;
        end
        default:      gate <= GATE_OFF;
      endcase
      if (wake) begin
        gate          <= GATE_OFF;
        gate_override <= 1'b1;
        drive_mode    <= MSS_DRV_IDLE;
        trapezoid_run <= 1'b0;
      end
    end
  end

  // Low sides stay on for the whole stationary brake
  property p_stat_brake_gate;
    @(posedge core_clk) disable iff (!nrst)
      (state == S_STAT_BRAKE) |-> (gate == GATE_LOW && gate_override);
  endproperty
  a_stat_brake_gate: assert property (p_stat_brake_gate) else $error("brake gate wrong");

  // Coast leaves every transistor off
  property p_coast_off;
    @(posedge core_clk) disable iff (!nrst)
      (state == S_COAST) |-> (gate == GATE_OFF && gate_override);
  endproperty
  a_coast_off: assert property (p_coast_off) else $error("coast gate not off");

  // Power-on follows probe enable
  property p_power_on_branch;
    @(posedge core_clk) disable iff (!nrst)
      (state == S_POWER_ON && !wake) |=>
        (state == (cfg.spin_probe_enable ? S_PROBE : S_SHORT_DEC));
  endproperty
  a_power_on_branch: assert property (p_power_on_branch) else $error("bad probe branch");

  // Wake always restarts
  property p_wake_restart;
    @(posedge core_clk) disable iff (!nrst) wake |=> state == S_POWER_ON;
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("wake not restarting");

  // Start request is a single pulse
  property p_one_request;
    @(posedge core_clk) disable iff (!nrst) startup_req |=> !startup_req;
  endproperty
  a_one_request: assert property (p_one_request) else $error("repeated start request");

  // Brake side follows select
  property p_brake_side;
    @(posedge core_clk) disable iff (!nrst)
      (state == S_BRAKE && $stable(cfg.brake_side_select)) |->
        gate == (cfg.brake_side_select ? GATE_HIGH : GATE_LOW);
  endproperty
  a_brake_side: assert property (p_brake_side) else $error("brake side wrong");

  // Reverse decision without the reverse enable goes to coast decision
  property p_rev_gate;
    @(posedge core_clk) disable iff (!nrst)
      (state == S_REV_DEC && !wake && !cfg.reverse_drive_enable) |=> state == S_COAST_DEC;
  endproperty
  a_rev_gate: assert property (p_rev_gate) else $error("reverse drive not gated");

  // Closed loop state always runs trapezoidal commutation
  property p_closed_trap;
    @(posedge core_clk) disable iff (!nrst)
      (state == S_CLOSED && !wake) |-> trapezoid_run;
  endproperty
  a_closed_trap: assert property (p_closed_trap) else $error("closed loop idle");

endmodule : mss_start_sequencer

// *** logic/mss_pkg.sv ***
// Package for the motor start sequencer: drive modes, carriers and timing constants
package mss_pkg;

  // Clock rate, timer width and data field widths
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned TIMER_W      = 24;
  localparam int unsigned BEMF_W       = 12;
  localparam int unsigned SPEED_W      = 16;
  localparam int unsigned POS_W        = 3;
  localparam int unsigned CURR_W       = 12;

  // Default durations in microseconds, converted to core clock cycles
  localparam int unsigned STAT_BRAKE_US = 100_000;
  localparam int unsigned COAST_US      = 100_000;
  localparam int unsigned BRAKE_US      = 100_000;
  localparam int unsigned US_CYCLES     = CLK_HZ / 1_000_000;
  localparam int unsigned STAT_BRAKE_CYC = STAT_BRAKE_US * US_CYCLES;
  localparam int unsigned COAST_CYC      = COAST_US * US_CYCLES;
  localparam int unsigned BRAKE_CYC      = BRAKE_US * US_CYCLES;

  // Power stage gate pattern, one bit per transistor
  typedef struct packed {
    logic [2:0] high_on;
    logic [2:0] low_on;
  } mss_gate_t;

  localparam mss_gate_t GATE_OFF  = '{high_on: 3'h0, low_on: 3'h0};
  localparam mss_gate_t GATE_LOW  = '{high_on: 3'h0, low_on: 3'h7};
  localparam mss_gate_t GATE_HIGH = '{high_on: 3'h7, low_on: 3'h0};

  // Result of the spin probe
  typedef struct packed {
    logic [BEMF_W-1:0]  bemf;
    logic [SPEED_W-1:0] speed;
    logic [POS_W-1:0]   position;
    logic               reverse;
  } mss_probe_t;

  // Static configuration
  typedef struct packed {
    logic               spin_probe_enable;
    logic               reverse_drive_enable;
    logic               stationary_brake_enable;
    logic               catch_spin_enable;
    logic               coast_enable;
    logic               shorting_stage_enable;
    logic               brake_end_select;   // 0: time, 1: current
    logic               brake_side_select;  // 0: low side, 1: high side
    logic [BEMF_W-1:0]  stationary_bemf_limit;
    logic [BEMF_W-1:0]  catch_spin_min_bemf;
    logic [SPEED_W-1:0] loop_handoff_speed;
    logic [CURR_W-1:0]  brake_current_limit;
  } mss_cfg_t;

  typedef enum logic [1:0] {
    MSS_DRV_IDLE,
    MSS_DRV_CLOSED,
    MSS_DRV_REV_CLOSED,
    MSS_DRV_REV_OPEN
  } mss_drive_t;

endpackage : mss_pkg

// *** logic/mss_timer.sv ***
// Down-counting duration timer with load and done flag
`timescale 1ns/1ps
module mss_timer #(
  parameter int unsigned W = 24
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] cycles,
  output logic              done
);
  logic [W-1:0] count;
  logic         run;

  // Count down after load; done pulses when count reaches one
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      run   <= 1'b0;
    end else if (load) begin
      count <= (cycles == '0) ? W'(1) : cycles;
      run   <= 1'b1;
    end else if (run) begin
      count <= count - W'(1);
      if (count == W'(1)) run <= 1'b0;
    end
  end

  assign done = run && (count == W'(1)) && !load;
endmodule : mss_timer

// *** logic/mss_current_cmp.sv ***
// Checks whether all three phase currents lie below a limit
`timescale 1ns/1ps
module mss_current_cmp #(
  parameter int unsigned W = 12
) (
  input  wire logic [3*W-1:0] phase_current,
  input  wire logic [W-1:0]   limit,
  output logic                all_below
);
  logic [2:0] below;

  // One compare per phase
  for (genvar i = 0; i < 3; i++) begin : g_ph
    assign below[i] = phase_current[i*W +: W] < limit;
  end

  assign all_below = &below;
endmodule : mss_current_cmp

// *** tb/mss_motor_model.sv ***
// Behavioural motor, converter and start-up helper facing the start sequencer
`timescale 1ns/1ps
module mss_motor_model
  import mss_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    nrst,
  input  wire mss_pkg::mss_probe_t     probe_set,
  input  wire logic                    probe_start,
  input  wire logic                    startup_req,
  input  wire mss_pkg::mss_drive_t     drive_mode,
  input  wire logic                    drive_reverse,
  input  wire mss_pkg::mss_gate_t      gate,
  input  wire logic                    gate_override,
  output mss_pkg::mss_probe_t          sample,
  output logic                         sample_valid,
  output logic [3*mss_pkg::CURR_W-1:0] phase_current,
  output logic [mss_pkg::SPEED_W-1:0]  drive_speed,
  output logic                         zero_crossed,
  output logic                         forward_ready,
  output logic                         startup_done
);
  logic [3:0] probe_cnt;
  logic [3:0] brk_cnt;
  logic [3:0] move_cnt;
  logic [3:0] done_cnt;
  logic       rev_q;
  logic       shorted;

  // Converter answers three cycles after the request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) probe_cnt <= 4'h0;
    else if (probe_cnt != 4'h0) probe_cnt <= probe_cnt - 4'h1;
    else if (probe_start) probe_cnt <= 4'h3;
  end
  assign sample_valid = (probe_cnt == 4'h1);
  assign sample       = sample_valid ? probe_set : ~probe_set; // Stale data never repeats

  // Phase currents decay six cycles into a short
  assign shorted = gate_override && (gate == GATE_LOW || gate == GATE_HIGH);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) brk_cnt <= 4'h0;
    else if (!shorted) brk_cnt <= 4'h0;
    else if (brk_cnt != 4'hf) brk_cnt <= brk_cnt + 4'h1;
  end
  assign phase_current = (brk_cnt >= 4'h6) ? {3{12'h010}} : {3{12'h800}};

  // Rotor slows under reverse closed loop, then crosses zero and speeds up
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drive_speed <= 16'h0000;
      move_cnt    <= 4'h0;
      rev_q       <= 1'b0;
    end else begin
      rev_q <= drive_reverse;
      if (drive_mode != MSS_DRV_REV_CLOSED) drive_speed <= probe_set.speed;
      else if (drive_speed > 16'h0100) drive_speed <= drive_speed - 16'h0100;
      else drive_speed <= 16'h0000;
      if (drive_mode != MSS_DRV_REV_OPEN || drive_reverse != rev_q) move_cnt <= 4'h0;
      else if (move_cnt != 4'hf) move_cnt <= move_cnt + 4'h1;
    end
  end
  assign zero_crossed  = (drive_mode == MSS_DRV_REV_OPEN) && drive_reverse && (move_cnt >= 4'h4);
  // Forward ramp counts only from the cycle after the direction flip
  assign forward_ready = (drive_mode == MSS_DRV_REV_OPEN) && !drive_reverse
                         && !rev_q && (move_cnt >= 4'h4);

  // Start-up helper finishes five cycles after its request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) done_cnt <= 4'h0;
    else if (startup_req) done_cnt <= 4'h5;
    else if (done_cnt != 4'h0) done_cnt <= done_cnt - 4'h1;
  end
  assign startup_done = (done_cnt == 4'h1);
endmodule : mss_motor_model

// *** tb/test_motor_start_sequencer.sv ***
// Self-checking bench for the motor start sequencer
`timescale 1ns/1ps
module test_motor_start_sequencer;
  import mss_pkg::*;
  logic                    core_clk;
  logic                    nrst;
  logic                    wake;
  logic                    dir_change_pending;
  mss_cfg_t                cfg;
  mss_probe_t              probe_set;
  mss_probe_t              sample;
  logic                    sample_valid;
  logic [3*CURR_W-1:0]     phase_current;
  logic [SPEED_W-1:0]      drive_speed;
  logic                    zero_crossed;
  logic                    forward_ready;
  logic                    startup_done;
  logic                    probe_start;
  logic                    startup_req;
  logic                    drive_load;
  mss_drive_t              drive_mode;
  logic                    drive_reverse;
  logic                    trapezoid_run;
  mss_probe_t              drive_init;
  mss_gate_t               gate;
  logic                    gate_override;
  int                      seed = 77;
  int                      fail_count = 0;
  int                      samples_checked = 0;
  int                      i;
  logic [11:0]             bemf_tab [5] = '{12'h080, 12'h100, 12'h150, 12'h200, 12'h300};
  logic [15:0]             speed_tab [3] = '{16'h0400, 16'h0800, 16'h2000};

  mss_start_sequencer #(.STAT_BRAKE_CYCLES(10), .COAST_CYCLES(12), .BRAKE_CYCLES(14)) uut (
    .core_clk(core_clk), .nrst(nrst), .wake(wake), .dir_change_pending(dir_change_pending),
    .cfg(cfg), .sample_bemf(sample.bemf), .sample_speed(sample.speed),
    .sample_position(sample.position), .sample_reverse(sample.reverse),
    .sample_valid(sample_valid), .phase_current(phase_current), .drive_speed(drive_speed),
    .zero_crossed(zero_crossed), .forward_ready(forward_ready), .startup_done(startup_done),
    .probe_start(probe_start), .startup_req(startup_req), .drive_load(drive_load),
    .drive_mode(drive_mode), .drive_reverse(drive_reverse), .trapezoid_run(trapezoid_run),
    .drive_init(drive_init), .gate(gate), .gate_override(gate_override));

  mss_motor_model motor (
    .core_clk(core_clk), .nrst(nrst), .probe_set(probe_set), .probe_start(probe_start),
    .startup_req(startup_req), .drive_mode(drive_mode), .drive_reverse(drive_reverse),
    .gate(gate), .gate_override(gate_override), .sample(sample),
    .sample_valid(sample_valid), .phase_current(phase_current), .drive_speed(drive_speed),
    .zero_crossed(zero_crossed), .forward_ready(forward_ready),
    .startup_done(startup_done));

  // Core clock, 40 ns period
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Expected path: {stat brake, coast, brake, catch, reverse drive}
  function automatic logic [4:0] plan(mss_cfg_t c, mss_probe_t p, logic dchg);
    logic stat_dec = 1'b0;
    logic short_dec = 1'b0;
    logic coast_dec = 1'b0;
    plan = 5'h00;
    if (!c.spin_probe_enable) short_dec = 1'b1;
    else if (p.bemf < c.stationary_bemf_limit) stat_dec = 1'b1;
    else if (!(p.reverse | dchg)) begin
      if (!c.catch_spin_enable) coast_dec = 1'b1;
      else if (p.bemf > c.catch_spin_min_bemf) plan[1] = 1'b1;
      else stat_dec = 1'b1;
    end else if (c.reverse_drive_enable) plan[0] = 1'b1;
    else coast_dec = 1'b1;
    if (coast_dec) plan[3] = c.coast_enable;
    if (coast_dec) short_dec = 1'b1;
    if (stat_dec) plan[4] = c.stationary_brake_enable;
    if (short_dec) plan[2] = c.shorting_stage_enable;
  endfunction : plan

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // Configuration and rotor state for one start, driven just after an edge
  task automatic set_case(input logic [7:0] en, input logic [11:0] bemf,
                          input logic [15:0] speed, input logic rev, input logic dchg);
    mss_cfg_t c;
    c = '0;
    c[$bits(mss_cfg_t)-1 -: 8] = en;
    c.stationary_bemf_limit = 12'h100;
    c.catch_spin_min_bemf = 12'h200;
    c.loop_handoff_speed = 16'h0800;
    c.brake_current_limit = 12'h100;
    cfg <= c;
    probe_set <= '{bemf: bemf, speed: speed, position: 3'($random(seed)), reverse: rev};
    dir_change_pending <= dchg;
  endtask : set_case

  // One start sequence, watched until closed loop has held three cycles
  task automatic run_case(input logic use_wake);
    logic [4:0] p;
    logic       saw_rc = 1'b0;
    int         n_low = 0;
    int         n_high = 0;
    int         n_off = 0;
    int         loads = 0;
    int         reqs = 0;
    int         prog = 0;
    int         hold = 0;
    int         k;
    mss_probe_t got_init = '0;
    if (use_wake) begin
      @(posedge core_clk);
      wake <= 1'b1;
      @(posedge core_clk);
      wake <= 1'b0;
    end
    p = plan(cfg, probe_set, dir_change_pending);
    for (k = 0; k < 600 && hold < 3; k++) begin
      @(posedge core_clk);
      #1;
      if (gate_override === 1'b1 && gate === GATE_LOW) n_low++;
      if (gate_override === 1'b1 && gate === GATE_HIGH) n_high++;
      if (gate_override === 1'b1 && gate === GATE_OFF && reqs == 0 && loads == 0
          && drive_mode === MSS_DRV_IDLE) n_off++;
      if (drive_load === 1'b1) got_init = drive_init;
      if (drive_load === 1'b1) loads++;
      if (startup_req === 1'b1) reqs++;
      if (drive_mode === MSS_DRV_REV_CLOSED && drive_reverse === 1'b1) saw_rc = 1'b1;
      if (prog == 0 && drive_mode === MSS_DRV_REV_OPEN && drive_reverse === 1'b1) prog = 2;
      if (prog == 2 && drive_mode === MSS_DRV_REV_OPEN && drive_reverse === 1'b0) prog = 3;
      if (prog == 3 && drive_mode === MSS_DRV_CLOSED) prog = 4;
      if (trapezoid_run === 1'b1) hold++;
    end
    if (hold < 3) begin
      fail_count++;
      $display("CHECK FAILED closed loop expected reached seen timeout");
      final_report();
    end
    if (p[2] && cfg.brake_end_select) begin
      check("current brake span", 32'((cfg.brake_side_select ? n_high : n_low) inside {[6:13]}),
            32'h1);
      if (cfg.brake_side_select) n_high = 14;
      else n_low = 14;
    end
    check("low side cycles", n_low, p[4] ? 10 : ((p[2] && !cfg.brake_side_select) ? 14 : 0));
    check("high side cycles", n_high, (p[2] && cfg.brake_side_select) ? 14 : 0);
    check("coast span", 32'(n_off >= 12), 32'(p[3]));
    check("load pulses", loads, 32'(p[1]));
    if (p[1]) check("probe data", got_init, probe_set);
    check("start requests", reqs, 32'(!(p[1] || p[0])));
    check("reverse order", prog, p[0] ? 4 : 0);
    check("reverse closed", 32'(saw_rc), 32'(p[0] && probe_set.speed >= 16'h0800));
    check("final mode", drive_mode, MSS_DRV_CLOSED);
  endtask : run_case

  task automatic go(input logic [7:0] en, input logic [11:0] bemf,
                    input logic [15:0] speed, input logic rev, input logic dchg);
    @(posedge core_clk);
    set_case(en, bemf, speed, rev, dchg);
    run_case(1'b1);
  endtask : go

  // Main sequence: power-up walk, corners, mid-run reset, random starts
  initial begin
    nrst = 1'b0;
    wake = 1'b0;
    dir_change_pending = 1'b0;
    cfg = '0;
    probe_set = '0;
    set_case(8'h00, 12'h080, 16'h0400, 1'b0, 1'b0);
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    run_case(1'b0);
    go(8'ha0, 12'h080, 16'h0400, 1'b0, 1'b0);
    go(8'h94, 12'h200, 16'h0400, 1'b0, 1'b0);
    go(8'hc0, 12'h300, 16'h0800, 1'b1, 1'b0);
    go(8'hc0, 12'h300, 16'h0400, 1'b0, 1'b1);
    go(8'h8f, 12'h300, 16'h0400, 1'b0, 1'b0);
    go(8'h88, 12'h300, 16'h0400, 1'b1, 1'b0);
    @(posedge core_clk);
    set_case(8'ha0, 12'h080, 16'h0400, 1'b0, 1'b0);
    @(posedge core_clk);
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    run_case(1'b0);
    for (i = 0; i < 40; i++) begin
      go(8'($random(seed)), bemf_tab[{$random(seed)} % 5], speed_tab[{$random(seed)} % 3],
         1'($random(seed)), 1'($random(seed)));
    end
    final_report();
  end
endmodule : test_motor_start_sequencer
